// ---- src/tap_cfg_defs.vh ----
`ifndef TAP_CFG_DEFS_VH
`define TAP_CFG_DEFS_VH

// ----------------------------------------------------------------
// Instruction codes
// ----------------------------------------------------------------
`define IR_WIDTH          8
`define IR_EXT_DRIVE      8'h00
`define IR_ID_READ        8'h01
`define IR_INT_DRIVE      8'h02
`define IR_SAMPLE         8'h03
`define IR_BYPASS         8'hFF
`define IR_USER_READ      8'hFD
`define IR_FLOAT          8'hFC
`define IR_HOLD           8'hFA
// Programming command codes (in-system programming set)
`define IR_ISP_ENABLE     8'hE8
`define IR_ISP_PROGRAM    8'hEA
`define IR_ISP_ERASE      8'hED
`define IR_ISP_DISABLE    8'hC0
`define IR_ISP_SWITCH     8'hF0

// ----------------------------------------------------------------
// Tap states (one-hot, 16 states)
// ----------------------------------------------------------------
`define TS_RESET          16'h0001
`define TS_IDLE           16'h0002
`define TS_SEL_DR         16'h0004
`define TS_CAP_DR         16'h0008
`define TS_SHIFT_DR       16'h0010
`define TS_EXIT1_DR       16'h0020
`define TS_PAUSE_DR       16'h0040
`define TS_EXIT2_DR       16'h0080
`define TS_UPD_DR         16'h0100
`define TS_SEL_IR         16'h0200
`define TS_CAP_IR         16'h0400
`define TS_SHIFT_IR       16'h0800
`define TS_EXIT1_IR       16'h1000
`define TS_PAUSE_IR       16'h2000
`define TS_EXIT2_IR       16'h4000
`define TS_UPD_IR         16'h8000

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS     50
`define SWITCH_MIN_US     50
`define SWITCH_MAX_US     100
`define SWITCH_CYCLES     ((`SWITCH_MIN_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TCK_MAX_MHZ       66

`endif

// ---- src/tap_cfg_ctrl.v ----
// Behaviour
// - All-zero instruction drives boundary cell contents onto output pins.
// - Code 03 captures pin input values into boundary cells, pins stay normal.
// - Code FF puts the one-bit bypass register between data in and out.
// - Code 02 feeds boundary cell values to core inputs instead of pins.
// - Code FC floats every output driver while selected.
// - Code FA freezes outputs at values held when it took effect.
// - Test clock limit is 66 MHz; sampling on the 20 MHz reference clock supports far less.
// - Programming command set is decoded alongside the test instructions.
// - New pattern may be written while loaded pattern keeps running.
// - During pattern switch-over pins float with weak pull-up, 50-100 us.
// - Every pin stays disabled until power-up has completed.
// - Power-up copies stored configuration into volatile cells first.
// - After power-up each pin of a programmed device takes its configured direction.
// - Stay quiescent until core supply good is asserted.
// - Quiescent: test port off, outputs off with pull-ups, core held.
// - Leaving quiescence initialises user registers, ready without delay.
// - Erased device: outputs off with pull-ups, test port enabled.
// - Programmed device: pins as configured, test port enabled.
`include "tap_cfg_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module tap_cfg_ctrl #(
	parameter         NPINS      = 8,
	parameter         CFG_WORDS  = 16,
	parameter         CFG_W      = 32,
	parameter         SWITCH_CYC = `SWITCH_CYCLES,
	parameter [31:0]  ID_VALUE   = 32'h0000_1001 // Arbitrary identity value
) (
	// Clock and reset
	input  wire               ref_clk,
	input  wire               rst_n,
	// Power sequencing
	input  wire               core_supply_good,
	output reg                por_done_q,
	output reg                device_programmed_q,
	output reg                user_reset_q,
	output reg                core_enable_q,
	// Test port pins
	input  wire               tck,
	input  wire               tms,
	input  wire               tdi,
	output reg                tdo_q,
	output reg                tdo_oe_q,
	// Pin side of boundary
	input  wire [NPINS-1:0]   pin_in,
	output reg  [NPINS-1:0]   pin_out_q,
	output reg  [NPINS-1:0]   pin_oe_q,
	output reg  [NPINS-1:0]   pin_pullup_q,
	// Core side of boundary
	input  wire [NPINS-1:0]   core_out,
	input  wire [NPINS-1:0]   core_oe,
	output reg  [NPINS-1:0]   core_in_q,
	// Nonvolatile store
	output reg  [3:0]         nv_addr_q,
	input  wire [CFG_W-1:0]   nv_rdata,
	output reg                nv_we_q,
	output reg  [CFG_W-1:0]   nv_wdata_q,
	// Loaded configuration view
	output reg  [NPINS-1:0]   cfg_pin_is_out_q,
	output reg                live_reprogram_q
);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	reg [3:0] sync1_q;
	reg [3:0] sync2_q;
	reg       tck_prev_q;
	// Two flops per pin; the first stage feeds no logic, and tck has a third flop for edge detection
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			sync1_q    <= 4'h0;
			sync2_q    <= 4'h0;
			tck_prev_q <= 1'b0;
		end else begin
			sync1_q    <= {core_supply_good, tdi, tms, tck};
			sync2_q    <= sync1_q;
			tck_prev_q <= sync2_q[0];
		end
	end
	wire tck_s   = sync2_q[0];
	wire tms_s   = sync2_q[1];
	wire tdi_s   = sync2_q[2];
	wire supply_s = sync2_q[3];
	// Sampling 20 MHz limits usable test clock far below 66 MHz
	wire tck_rise = tck_s & ~tck_prev_q;
	wire tck_fall = ~tck_s & tck_prev_q;

	// ----------------------------------------------------------------
	// Power-up sequencer
	// ----------------------------------------------------------------
	localparam [4:0] PS_QUIET = 5'h01;
	localparam [4:0] PS_LOAD  = 5'h02;
	localparam [4:0] PS_RUN   = 5'h04;
	localparam [4:0] PS_SWAP  = 5'h08;
	localparam [4:0] PS_INIT  = 5'h10;

	reg [4:0]        pstate_q;
	reg [15:0]       swap_cnt_q;
	reg [CFG_W-1:0]  cfg_mem [0:CFG_WORDS-1];
	reg [CFG_W-1:0]  usercode_q;
	reg              tap_enable_q;
	reg              swap_req_q;
	reg              swap_ack_q;
	wire             erased = (usercode_q == {CFG_W{1'b1}});

	always @(posedge ref_clk) begin
		if (!rst_n) begin
			pstate_q            <= PS_QUIET;
			nv_addr_q           <= 4'h0;
			swap_cnt_q          <= 16'h0000;
			por_done_q          <= 1'b0;
			tap_enable_q        <= 1'b0;
			core_enable_q       <= 1'b0;
			user_reset_q        <= 1'b1;
			device_programmed_q <= 1'b0;
			usercode_q          <= {CFG_W{1'b1}};
			cfg_pin_is_out_q    <= {NPINS{1'b0}};
			swap_ack_q          <= 1'b0;
		end else begin
			swap_ack_q <= 1'b0;
			case (pstate_q)
			PS_QUIET: begin
				// Test port, core and pins held off
				tap_enable_q  <= 1'b0;
				core_enable_q <= 1'b0;
				user_reset_q  <= 1'b1;
				nv_addr_q     <= 4'h0;
				if (supply_s)
					pstate_q <= PS_LOAD;
			end
			PS_LOAD: begin
				// Copy nonvolatile words into volatile cells
				cfg_mem[nv_addr_q] <= nv_rdata;
				nv_addr_q          <= nv_addr_q + 4'h1;
				if (nv_addr_q == 4'h0)
					usercode_q <= nv_rdata;
				if (nv_addr_q == 4'h1)
					cfg_pin_is_out_q <= nv_rdata[NPINS-1:0];
				if (nv_addr_q == CFG_WORDS[3:0] - 4'h1)
					pstate_q <= PS_INIT;
			end
			PS_INIT: begin
				// Release user register reset held through the load, then run
				user_reset_q        <= 1'b0;
				por_done_q          <= 1'b1;
				tap_enable_q        <= 1'b1;
				device_programmed_q <= ~erased;
				core_enable_q       <= ~erased;
				pstate_q            <= PS_RUN;
			end
			PS_RUN: begin
				// Store address follows the programming pointer while running
				nv_addr_q <= prog_addr_q;
				if (swap_req_q) begin
					swap_ack_q    <= 1'b1;
					swap_cnt_q    <= 16'h0000;
					core_enable_q <= 1'b0;
					nv_addr_q     <= 4'h0;
					pstate_q      <= PS_SWAP;
				end
			end
			PS_SWAP: begin
				// Pins float for the switch-over time, then reload
				swap_cnt_q <= swap_cnt_q + 16'h0001;
				if (swap_cnt_q == SWITCH_CYC[15:0] - 16'h0001) begin
					user_reset_q <= 1'b1;
					pstate_q     <= PS_LOAD;
				end
			end
			default: pstate_q <= PS_QUIET;
			endcase
			// Supply loss drops state, power-up flag, port and core at once, not one state later; programmed flag and config kept
			if (!supply_s) begin
				pstate_q      <= PS_QUIET;
				por_done_q    <= 1'b0;
				tap_enable_q  <= 1'b0;
				core_enable_q <= 1'b0;
				user_reset_q  <= 1'b1;
			end
		end
	end
	wire swapping = (pstate_q == PS_SWAP) | ((pstate_q == PS_LOAD) & por_done_q) | live_reprogram_q;

	// ----------------------------------------------------------------
	// Tap controller
	// ----------------------------------------------------------------
	reg [15:0]        ts_q;
	reg [15:0]        ts_d;
	reg [`IR_WIDTH-1:0] ir_sh_q;
	reg [`IR_WIDTH-1:0] ir_q;
	reg [CFG_W-1:0]   dr_q;
	reg [NPINS-1:0]   bsr_q;
	reg [NPINS-1:0]   bsr_upd_q;
	reg [NPINS-1:0]   hold_out_q;
	reg [NPINS-1:0]   hold_oe_q;
	reg               isp_en_q;
	reg [3:0]         prog_addr_q;

	// Next tap state from tms
	always @* begin
		case (ts_q)
		`TS_RESET:    ts_d = tms_s ? `TS_RESET   : `TS_IDLE;
		`TS_IDLE:     ts_d = tms_s ? `TS_SEL_DR  : `TS_IDLE;
		`TS_SEL_DR:   ts_d = tms_s ? `TS_SEL_IR  : `TS_CAP_DR;
		`TS_CAP_DR:   ts_d = tms_s ? `TS_EXIT1_DR : `TS_SHIFT_DR;
		`TS_SHIFT_DR: ts_d = tms_s ? `TS_EXIT1_DR : `TS_SHIFT_DR;
		`TS_EXIT1_DR: ts_d = tms_s ? `TS_UPD_DR  : `TS_PAUSE_DR;
		`TS_PAUSE_DR: ts_d = tms_s ? `TS_EXIT2_DR : `TS_PAUSE_DR;
		`TS_EXIT2_DR: ts_d = tms_s ? `TS_UPD_DR  : `TS_SHIFT_DR;
		`TS_UPD_DR:   ts_d = tms_s ? `TS_SEL_DR  : `TS_IDLE;
		`TS_SEL_IR:   ts_d = tms_s ? `TS_RESET   : `TS_CAP_IR;
		`TS_CAP_IR:   ts_d = tms_s ? `TS_EXIT1_IR : `TS_SHIFT_IR;
		`TS_SHIFT_IR: ts_d = tms_s ? `TS_EXIT1_IR : `TS_SHIFT_IR;
		`TS_EXIT1_IR: ts_d = tms_s ? `TS_UPD_IR  : `TS_PAUSE_IR;
		`TS_PAUSE_IR: ts_d = tms_s ? `TS_EXIT2_IR : `TS_PAUSE_IR;
		`TS_EXIT2_IR: ts_d = tms_s ? `TS_UPD_IR  : `TS_SHIFT_IR;
		`TS_UPD_IR:   ts_d = tms_s ? `TS_SEL_DR  : `TS_IDLE;
		default:      ts_d = `TS_RESET;
		endcase
	end

	// Decode of the active instruction
	wire i_ext   = (ir_q == `IR_EXT_DRIVE);
	wire i_samp  = (ir_q == `IR_SAMPLE);
	wire i_int   = (ir_q == `IR_INT_DRIVE);
	wire i_float = (ir_q == `IR_FLOAT);
	wire i_hold  = (ir_q == `IR_HOLD);
	wire i_id    = (ir_q == `IR_ID_READ);
	wire i_user  = (ir_q == `IR_USER_READ);
	wire i_ispen = (ir_q == `IR_ISP_ENABLE);
	wire i_prog  = (ir_q == `IR_ISP_PROGRAM);
	wire i_erase = (ir_q == `IR_ISP_ERASE);
	wire i_ispdis = (ir_q == `IR_ISP_DISABLE);
	wire i_swap  = (ir_q == `IR_ISP_SWITCH);
	wire i_bsr   = i_ext | i_samp | i_int;
	wire i_wide  = i_id | i_user | i_prog;
	// Anything else, including all-ones, is bypass
	wire i_byp   = ~(i_bsr | i_wide | i_float | i_hold | i_ispen | i_erase | i_ispdis | i_swap);

	wire tap_step = tap_enable_q & tck_rise;
	// Bypass uses only bit 0, so it is a single-bit path
	wire dr_tail  = i_bsr ? bsr_q[0] : dr_q[0];

	// Tap state, shift registers and updates on test clock rise
	always @(posedge ref_clk) begin
		if (!rst_n || !tap_enable_q) begin
			ts_q        <= `TS_RESET;
			ir_sh_q     <= 8'h00;
			ir_q        <= `IR_ID_READ;
			dr_q        <= {CFG_W{1'b0}};
			bsr_q       <= {NPINS{1'b0}};
			bsr_upd_q   <= {NPINS{1'b0}};
			isp_en_q    <= 1'b0;
			prog_addr_q <= 4'h0;
			nv_we_q     <= 1'b0;
			nv_wdata_q  <= {CFG_W{1'b0}};
			swap_req_q  <= 1'b0;
			live_reprogram_q <= 1'b0;
		end else begin
			nv_we_q <= 1'b0;
			if (swap_ack_q)
				swap_req_q <= 1'b0;
			if (tap_step) begin
				ts_q <= ts_d;
				case (ts_q)
				`TS_RESET:    ir_q <= `IR_ID_READ;
				`TS_CAP_IR:   ir_sh_q <= 8'h01;
				`TS_SHIFT_IR: ir_sh_q <= {tdi_s, ir_sh_q[7:1]};
				`TS_UPD_IR: begin
					ir_q <= ir_sh_q;
					if (ir_sh_q == `IR_ISP_ENABLE) begin
						isp_en_q    <= 1'b1;
						prog_addr_q <= 4'h0;
					end
				end
				`TS_CAP_DR: begin
					if (i_bsr)
						bsr_q <= i_int ? core_out : pin_in;
					else if (i_id)
						dr_q <= ID_VALUE[CFG_W-1:0];
					else if (i_user)
						dr_q <= usercode_q;
					else
						dr_q <= {CFG_W{1'b0}};
				end
				`TS_SHIFT_DR: begin
					if (i_bsr)
						bsr_q <= {tdi_s, bsr_q[NPINS-1:1]};
					else if (i_wide)
						dr_q <= {tdi_s, dr_q[CFG_W-1:1]};
					else
						dr_q <= {dr_q[CFG_W-1:1], tdi_s};
				end
				`TS_UPD_DR: begin
					if (i_bsr)
						bsr_upd_q <= bsr_q;
					// Writing the store leaves the running pattern alone
					if (i_prog && isp_en_q) begin
						nv_we_q     <= 1'b1;
						nv_wdata_q  <= dr_q;
						prog_addr_q <= prog_addr_q + 4'h1;
					end
					if (i_erase && isp_en_q) begin
						nv_we_q    <= 1'b1;
						nv_wdata_q <= {CFG_W{1'b1}};
					end
				end
				`TS_IDLE: begin
					if (i_ispdis)
						isp_en_q <= 1'b0;
					if (i_swap && isp_en_q && !swap_req_q) begin
						swap_req_q       <= 1'b1;
						live_reprogram_q <= 1'b1;
					end
				end
				default: ;
				endcase
			end
			if (pstate_q == PS_INIT)
				live_reprogram_q <= 1'b0;
		end
	end

	// Serial out changes on test clock fall
	always @(posedge ref_clk) begin
		if (!rst_n || !tap_enable_q) begin
			tdo_q    <= 1'b0;
			tdo_oe_q <= 1'b0;
		end else if (tck_fall) begin
			tdo_oe_q <= (ts_q == `TS_SHIFT_DR) | (ts_q == `TS_SHIFT_IR);
			tdo_q    <= (ts_q == `TS_SHIFT_IR) ? ir_sh_q[0] : dr_tail;
		end
	end

	// ----------------------------------------------------------------
	// Pin and core-input muxing
	// ----------------------------------------------------------------
	// Synced supply gates pins directly so they float on the first cycle of loss
	wire run_io = por_done_q & core_enable_q & ~swapping & supply_s;
	// Follows the pins every cycle outside the hold instruction, frozen while it is active
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			hold_out_q <= {NPINS{1'b0}};
			hold_oe_q  <= {NPINS{1'b0}};
		end else if (!i_hold) begin
			hold_out_q <= pin_out_q;
			hold_oe_q  <= pin_oe_q;
		end
	end

	always @(posedge ref_clk) begin
		if (!rst_n) begin
			pin_out_q    <= {NPINS{1'b0}};
			pin_oe_q     <= {NPINS{1'b0}};
			pin_pullup_q <= {NPINS{1'b1}};
			core_in_q    <= {NPINS{1'b0}};
		end else if (!run_io) begin
			// Quiescent, erased or switching: float with pull-up
			pin_out_q    <= {NPINS{1'b0}};
			pin_oe_q     <= {NPINS{1'b0}};
			pin_pullup_q <= {NPINS{1'b1}};
			core_in_q    <= {NPINS{1'b0}};
		end else begin
			pin_pullup_q <= ~cfg_pin_is_out_q;
			core_in_q    <= i_int ? bsr_upd_q : pin_in;
			if (i_ext) begin
				pin_out_q <= bsr_upd_q;
				pin_oe_q  <= cfg_pin_is_out_q;
			end else if (i_float) begin
				pin_oe_q  <= {NPINS{1'b0}};
			end else if (i_hold) begin
				pin_out_q <= hold_out_q;
				pin_oe_q  <= hold_oe_q;
			end else begin
				pin_out_q <= core_out;
				pin_oe_q  <= core_oe & cfg_pin_is_out_q;
			end
		end
	end

endmodule

`default_nettype wire

// ---- tb/tap_cfg_ctrl_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module tap_cfg_ctrl_props #(
	parameter NPINS      = 8,
	parameter CFG_WORDS  = 16,
	parameter SWITCH_CYC = 20
) (
	// Clock and reset
	input wire logic             ref_clk,
	input wire logic             rst_n,
	// Power and mode state
	input wire logic             core_supply_good,
	input wire logic             por_done_q,
	input wire logic             device_programmed_q,
	input wire logic             user_reset_q,
	input wire logic             core_enable_q,
	input wire logic             live_reprogram_q,
	// Pin controls
	input wire logic             tdo_oe_q,
	input wire logic [NPINS-1:0] pin_oe_q,
	input wire logic [NPINS-1:0] pin_pullup_q
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// ------------------------------------------------
	// Float window length, too long for a repetition
	// ------------------------------------------------
	logic [15:0] sw_cnt_q;
	logic [15:0] sw_cnt_d;
	assign sw_cnt_d = live_reprogram_q ? sw_cnt_q + 16'h0001 : 16'h0000;
	always_ff @(posedge ref_clk) begin
		sw_cnt_q <= rst_n ? sw_cnt_d : 16'h0000;
	end
	// ------------------------------------------------
	// Checks
	// ------------------------------------------------
	a_quiet_pins_off: assert property (!por_done_q |-> !(|pin_oe_q) && &pin_pullup_q)
		else $error("pins active before power-up done");
	a_quiet_port_off: assert property (!por_done_q |-> !tdo_oe_q)
		else $error("test port active while quiet");
	a_quiet_core_held: assert property (!por_done_q |-> user_reset_q && !core_enable_q)
		else $error("core running while quiet");
	a_supply_wait: assert property ((!core_supply_good) [*4] |=> !por_done_q)
		else $error("left quiet state without supply good");
	a_load_first: assert property ($rose(por_done_q) |-> !$past(por_done_q, CFG_WORDS) && $past(user_reset_q))
		else $error("power-up finished before load");
	a_core_ready: assert property ($rose(por_done_q) && device_programmed_q |-> ##[0:1] (!user_reset_q && core_enable_q))
		else $error("programmed core not started");
	a_erased_core_off: assert property (por_done_q && !device_programmed_q |-> !core_enable_q)
		else $error("erased device runs core");
	a_switch_float: assert property (live_reprogram_q && $past(live_reprogram_q) |-> !(|pin_oe_q) && &pin_pullup_q)
		else $error("pins driven during pattern switch");
	a_float_len: assert property ($fell(live_reprogram_q) |-> sw_cnt_q >= SWITCH_CYC)
		else $error("pattern switch too short");
	// Main scenarios reached
	c_powerup: cover property ($rose(por_done_q));
	c_swap: cover property ($fell(live_reprogram_q));
	c_shift: cover property ($rose(tdo_oe_q));
endmodule

bind tap_cfg_ctrl tap_cfg_ctrl_props #(.NPINS(NPINS), .CFG_WORDS(CFG_WORDS), .SWITCH_CYC(SWITCH_CYC)) u_props (
	.ref_clk(ref_clk), .rst_n(rst_n), .core_supply_good(core_supply_good), .por_done_q(por_done_q),
	.device_programmed_q(device_programmed_q), .user_reset_q(user_reset_q), .core_enable_q(core_enable_q),
	.live_reprogram_q(live_reprogram_q), .tdo_oe_q(tdo_oe_q), .pin_oe_q(pin_oe_q), .pin_pullup_q(pin_pullup_q));
`default_nettype wire

// ---- tb/jtag_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module jtag_host (
	// Pacing clock
	input wire logic ref_clk,
	// Test port
	output var logic tck,
	output var logic tms,
	output var logic tdi,
	input wire logic tdo_q
);
	// Clock parked low outside frames
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end
	// One test clock of 400 ns, well under the 66 MHz limit
	task automatic tick(input logic m, input logic d, output logic o);
		@(negedge ref_clk);
		tms = m;
		tdi = d;
		repeat (3) @(negedge ref_clk);
		tck = 1'b1;
		repeat (2) @(negedge ref_clk);
		o = tdo_q;
		repeat (2) @(negedge ref_clk);
		tck = 1'b0;
	endtask
	// Five ones reach reset from any state, then idle
	task automatic reset_tap();
		logic o;
		repeat (5) tick(1'b1, ~tdi, o);
		tick(1'b0, ~tdi, o);
	endtask
	// Scan from idle back to idle, LSB first; data line toggles after
	task automatic scan(input logic ir, input logic [31:0] d, input int n, output logic [31:0] q);
		logic o;
		q = 32'h0000_0000;
		tick(1'b1, ~tdi, o);
		if (ir)
			tick(1'b1, ~tdi, o);
		tick(1'b0, ~tdi, o);
		tick(1'b0, ~tdi, o);
		for (int i = 0; i < n; i++) begin
			tick(i == n - 1, d[i], o);
			q[i] = o;
		end
		tick(1'b1, ~tdi, o);
		tick(1'b0, ~tdi, o);
	endtask
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tap_cfg_defs.vh"
module tb;
	localparam int          SWC  = 20;
	localparam logic [31:0] ID_V = 32'h0000_0A5B; // Arbitrary identity value
	logic        ref_clk, rst_n, core_supply_good, tck, tms, tdi, tdo_q, tdo_oe_q, nv_we_q;
	logic        por_done_q, device_programmed_q, user_reset_q, core_enable_q, live_reprogram_q;
	logic [7:0]  pin_in, core_out, core_oe, pin_out_q, pin_oe_q, pin_pullup_q, core_in_q, cfg_pin_is_out_q;
	logic [3:0]  nv_addr_q;
	logic [31:0] nv_rdata, nv_wdata_q, q;
	logic [31:0] nv_mem [16];
	int          n_errors, samples_checked, cyc, n_we;
	// ------------------------------------------------
	// Device, host and store
	// ------------------------------------------------
	tap_cfg_ctrl #(.SWITCH_CYC(SWC), .ID_VALUE(ID_V)) u_tap_cfg_ctrl (.ref_clk, .rst_n, .core_supply_good,
		.por_done_q, .device_programmed_q, .user_reset_q, .core_enable_q, .tck, .tms, .tdi, .tdo_q, .tdo_oe_q,
		.pin_in, .pin_out_q, .pin_oe_q, .pin_pullup_q, .core_out, .core_oe, .core_in_q, .nv_addr_q, .nv_rdata,
		.nv_we_q, .nv_wdata_q, .cfg_pin_is_out_q, .live_reprogram_q);
	jtag_host u_jtag_host (.ref_clk, .tck, .tms, .tdi, .tdo_q);
	// Store read is combinational, writes land on the clock
	assign nv_rdata = nv_mem[nv_addr_q];
	always @(posedge ref_clk) begin
		if (nv_we_q === 1'b1) begin
			nv_mem[nv_addr_q] <= nv_wdata_q;
			n_we <= n_we + 1;
		end
	end
	// Clock and hang guard
	always #25 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			n_errors++;
			finish_test();
		end
	end
	// ------------------------------------------------
	// Helpers
	// ------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wait_hi(ref logic s, input int lim);
		for (int i = 0; i < lim && s !== 1'b1; i++)
			@(negedge ref_clk);
		chk(s, 1'b1);
	endtask
	task automatic ir(input logic [7:0] c);
		u_jtag_host.scan(1'b1, {24'h0, c}, 8, q);
	endtask
	task automatic dr(input logic [31:0] d, input int n);
		u_jtag_host.scan(1'b0, d, n, q);
	endtask
	task automatic finish_test();
		$display("checked=%0d errors=%0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// ------------------------------------------------
	// Scenarios
	// ------------------------------------------------
	// Port ignored while quiet; load, then run as configured
	task automatic t_powerup();
		u_jtag_host.reset_tap();
		ir(`IR_BYPASS);
		chk({por_done_q, pin_oe_q, pin_pullup_q}, 17'h000FF);
		chk({tdo_oe_q, user_reset_q, core_enable_q}, 3'b010);
		core_supply_good = 1'b1;
		wait_hi(por_done_q, 40);
		chk({user_reset_q, core_enable_q, device_programmed_q}, 3'b011);
		chk(cfg_pin_is_out_q, nv_mem[1][7:0]);
		repeat (2) @(negedge ref_clk);
		chk(pin_oe_q, nv_mem[1][7:0] & core_oe);
	endtask
	// Identity after port reset, identity and user code by code
	task automatic t_idreads();
		u_jtag_host.reset_tap();
		dr(32'h0, 32);
		chk(q, ID_V);
		ir(`IR_ID_READ);
		dr(32'h0, 32);
		chk(q, ID_V);
		ir(`IR_USER_READ);
		dr(32'h0, 32);
		chk(q, nv_mem[0]);
	endtask
	// Bypass and undefined codes give one-bit delay
	task automatic t_bypass();
		logic [7:0] codes [3] = '{`IR_BYPASS, 8'h55, 8'h7E};
		foreach (codes[k]) begin
			ir(codes[k]);
			dr(32'h0000_00B4, 8);
			chk(q[7:0], 8'h68);
		end
	endtask
	// Preload, drive pins, drive core, float, freeze
	task automatic t_boundary();
		logic [7:0] held;
		ir(`IR_SAMPLE);
		chk(pin_oe_q, cfg_pin_is_out_q & core_oe);
		dr(32'h0000_003C, 8);
		ir(`IR_EXT_DRIVE);
		chk(pin_out_q, 8'h3C);
		ir(`IR_INT_DRIVE);
		dr(32'h0000_00C3, 8);
		chk(core_in_q, 8'hC3);
		ir(`IR_FLOAT);
		chk(pin_oe_q, 8'h00);
		ir(`IR_BYPASS);
		held = pin_out_q;
		ir(`IR_HOLD);
		core_out = ~core_out;
		repeat (4) @(negedge ref_clk);
		chk(pin_out_q, held);
		ir(`IR_BYPASS);
	endtask
	// Write while running, then swap with pins floating
	task automatic t_switch();
		logic o;
		logic p;
		int n;
		ir(`IR_ISP_ENABLE);
		ir(`IR_ISP_PROGRAM);
		dr(32'hFFFF_FFFF, 32);
		chk(n_we > 0, 1'b1);
		chk(core_enable_q, 1'b1);
		ir(`IR_ISP_SWITCH);
		u_jtag_host.tick(1'b0, 1'b0, o);
		wait_hi(live_reprogram_q, 40);
		repeat (2) @(negedge ref_clk);
		chk({pin_oe_q, pin_pullup_q}, 16'h00FF);
		n = 0;
		while (live_reprogram_q === 1'b1 && n < 500) begin
			@(negedge ref_clk);
			n++;
		end
		chk(n >= SWC - 1 && n < 500, 1'b1);
		repeat (4) @(negedge ref_clk);
		p = nv_mem[0] !== 32'hFFFF_FFFF;
		chk({device_programmed_q, core_enable_q}, {p, p});
	endtask
	// Power cycle into an erased pattern; port still usable
	task automatic t_erased();
		core_supply_good = 1'b0;
		repeat (6) @(negedge ref_clk);
		chk(por_done_q, 1'b0);
		nv_mem[0] = 32'hFFFF_FFFF;
		core_supply_good = 1'b1;
		wait_hi(por_done_q, 40);
		chk({device_programmed_q, core_enable_q, pin_oe_q, pin_pullup_q}, 18'h000FF);
		u_jtag_host.reset_tap();
		dr(32'h0, 32);
		chk(q, ID_V);
	endtask
	// ------------------------------------------------
	// Main sequence
	// ------------------------------------------------
	initial begin
		ref_clk = 1'b0;
		rst_n = 1'b0;
		core_supply_good = 1'b0;
		pin_in = 8'h5A;
		core_out = 8'h96;
		core_oe = 8'hFF;
		{n_errors, samples_checked, cyc, n_we} = '0;
		foreach (nv_mem[i])
			nv_mem[i] = 32'h0000_0000;
		nv_mem[0] = 32'h0000_7E11;
		nv_mem[1] = 32'h0000_000F;
		repeat (3) @(negedge ref_clk);
		rst_n = 1'b1;
		repeat (20) @(negedge ref_clk);
		t_powerup();
		t_idreads();
		t_bypass();
		t_boundary();
		t_switch();
		t_erased();
		finish_test();
	end
endmodule
`default_nettype wire
